/* gxp_cfg.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the port extender.
// Assumes: 100 MHz core clock, registers on a 32-bit bus at byte addresses.
// Notes: Included by its bare name; definitions only.
`ifndef GXP_CFG_SVH
`define GXP_CFG_SVH
`define GXP_OFS_PORT0 8'h00
`define GXP_OFS_DEBOUNCE 8'h14
`define GXP_OFS_BUCK 8'h18
`define GXP_OFS_EVENT 8'h1c
`define GXP_OFS_MASK 8'h20
`define GXP_OFS_STATUS 8'h24
`define GXP_OFS_VSEL 8'h28
`define GXP_PORT_RST 6'h00
`define GXP_BUCK_RST 26'h0
`define GXP_DEBOUNCE_RST 8'h0a
`define GXP_MASK_RST 8'h00
`define GXP_VSEL_RST 3'h0
`define GXP_FUNC_INPUT 2'h0
`define GXP_FUNC_ALT 2'h1
`define GXP_FUNC_OUTPUT 2'h2
`define GXP_ALT_SO_PORT 3
`define GXP_ALT_CS_PORT 4
`define GXP_ST_BUCKA 8
`define GXP_ST_BUCKB 9
`define GXP_ST_ALT 10
`define GXP_ST_ON 11
`define GXP_ST_ADDR2 12
`define GXP_CLK_HZ 100000000
`define GXP_DEBOUNCE_UNIT_MS 1
`define GXP_CYC_PER_UNIT (`GXP_CLK_HZ / 1000 * `GXP_DEBOUNCE_UNIT_MS)
`endif

/* gxp_pkg.sv */
// Purpose: Types shared by the port extender.
// Assumes: Field layouts match the register map in gxp_cfg.svh.
// Notes: Nothing here holds a number of its own.
`default_nettype none
package gxp_pkg;
	typedef struct packed {
		logic openDrain;
		logic pullEn;
		logic behaviour;
		logic polarity;
		logic [1:0] func;
	} gxp_portcfg_s;
	typedef struct packed {
		logic [2:0] addrInSel;
		logic addrSelEn;
		logic [2:0] pgPortB;
		logic [2:0] pgPortA;
		logic pdDisB;
		logic pdDisA;
		logic [2:0] vselInB;
		logic [2:0] vselInA;
		logic [2:0] enInB;
		logic [2:0] enInA;
		logic enB;
		logic enA;
	} gxp_buck_s;
endpackage : gxp_pkg
`default_nettype wire

/* gxp_extender.sv */
// Purpose: Port extender with debounce, events, buck control and power-good outputs.
// Assumes: Pins are synchronous-safe after the two-stage synchronisers; one clock.
// Notes: Avalon-MM slave answers every access on the second cycle.
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`include "gxp_cfg.svh"
`default_nettype none
module gxp_extender #(
	parameter int NUM_PORTS = 5,
	parameter int UNIT_CYCLES = `GXP_CYC_PER_UNIT
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic chipEnable,
	input wire logic fourWireStrap,
	input wire logic [NUM_PORTS-1:0] portIn,
	output logic [NUM_PORTS-1:0] portOut,
	output logic [NUM_PORTS-1:0] portOe,
	output logic [NUM_PORTS-1:0] portPullUpEn,
	output logic [NUM_PORTS-1:0] portPullDownEn,
	input wire logic ifSoData,
	input wire logic ifSoOe,
	output logic ifChipSelect,
	input wire logic powerGoodA,
	input wire logic powerGoodB,
	output logic buckAEn,
	output logic buckBEn,
	output logic buckAPulldownEn,
	output logic buckBPulldownEn,
	output logic buckAVoltageSel,
	output logic buckBVoltageSel,
	output logic inputSupplySel,
	output logic useSecondAddr,
	output logic interruptOut_n
);
	localparam int CW = $clog2(UNIT_CYCLES + 1);

	// The 3-bit port selectors and the interface pins need five to seven ports.
	if (NUM_PORTS < 5 || NUM_PORTS > 7) begin : gBadPorts
		$error("NUM_PORTS must be 5 to 7");
	end
	if (UNIT_CYCLES < 1) begin : gBadUnit
		$error("UNIT_CYCLES must be positive");
	end

	gxp_pkg::gxp_portcfg_s portCfg_r [NUM_PORTS];
	gxp_pkg::gxp_buck_s buck_r;
	logic [7:0] debounce_r;
	logic [NUM_PORTS-1:0] event_r;
	logic [NUM_PORTS-1:0] mask_r;
	logic [2:0] vsel_r;
	logic [2:0] vsel_nxt;
	logic [NUM_PORTS-1:0] syncA_r;
	logic [NUM_PORTS-1:0] syncB_r;
	logic [NUM_PORTS-1:0] status;
	logic [NUM_PORTS-1:0] prevStatus_r;
	logic [NUM_PORTS-1:0] preset;
	logic [NUM_PORTS-1:0] isInput;
	logic onMode_r;
	logic onPrev_r;
	logic fourWire_r;
	logic strapDone_r;
	logic altMode;
	logic [CW-1:0] unitCnt_r;
	logic unitTick;
	logic ack_r;
	logic wrEn;
	logic [31:0] wmask;
	logic [31:0] rdMux;
	logic buckAEn_r;
	logic buckBEn_r;
	logic buckAPd_r;
	logic buckBPd_r;
	logic addr2_r;
	logic irqN_r;
	logic ifCs_r;

	function automatic logic selBit(input logic [2:0] sel, input logic [NUM_PORTS-1:0] v);
		logic r;
		r = 1'b0;
		for (int k = 0; k < NUM_PORTS; k++) begin
			if (sel == 3'(k + 1)) begin
				r = v[k];
			end
		end
		return r;
	endfunction : selBit

	// Bus slave: waitrequest drops one cycle after the request rises.
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wrEn = avs_write & ack_r;
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
		end
	end

	always_comb begin
		rdMux = 32'h0;
		case (avs_address)
			`GXP_OFS_DEBOUNCE: rdMux[7:0] = debounce_r;
			`GXP_OFS_BUCK: rdMux[25:0] = buck_r;
			`GXP_OFS_EVENT: rdMux[NUM_PORTS-1:0] = event_r;
			`GXP_OFS_MASK: rdMux[NUM_PORTS-1:0] = mask_r;
			`GXP_OFS_VSEL: rdMux[2:0] = vsel_r;
			`GXP_OFS_STATUS: begin
				rdMux[NUM_PORTS-1:0] = status;
				rdMux[`GXP_ST_BUCKA] = buckAEn_r;
				rdMux[`GXP_ST_BUCKB] = buckBEn_r;
				rdMux[`GXP_ST_ALT] = altMode;
				rdMux[`GXP_ST_ON] = onMode_r;
				rdMux[`GXP_ST_ADDR2] = addr2_r;
			end
			default: begin
				for (int k = 0; k < NUM_PORTS; k++) begin
					if (avs_address == `GXP_OFS_PORT0 + 8'(4 * k)) begin
						rdMux[5:0] = portCfg_r[k];
					end
				end
			end
		endcase
	end

	// Read data is captured in the wait cycle, so it stands while waitrequest is low.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && !ack_r) begin
			avs_readdata <= rdMux;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			buck_r <= `GXP_BUCK_RST;
			debounce_r <= `GXP_DEBOUNCE_RST;
			mask_r <= NUM_PORTS'(`GXP_MASK_RST);
		end else if (wrEn) begin
			if (avs_address == `GXP_OFS_BUCK) begin
				buck_r <= (buck_r & ~wmask[25:0]) | (avs_writedata[25:0] & wmask[25:0]);
			end
			if (avs_address == `GXP_OFS_DEBOUNCE) begin
				debounce_r <= (debounce_r & ~wmask[7:0]) | (avs_writedata[7:0] & wmask[7:0]);
			end
			if (avs_address == `GXP_OFS_MASK && avs_byteenable[0]) begin
				mask_r <= avs_writedata[NUM_PORTS-1:0];
			end
		end
	end

	// Mode tracking and the start-up strap, caught once after reset release.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			onMode_r <= 1'b0;
			onPrev_r <= 1'b0;
			fourWire_r <= 1'b0;
			strapDone_r <= 1'b0;
		end else begin
			onMode_r <= chipEnable;
			onPrev_r <= onMode_r;
			if (!strapDone_r) begin
				fourWire_r <= fourWireStrap;
				strapDone_r <= 1'b1;
			end
		end
	end

	assign altMode = fourWire_r ||
		(portCfg_r[`GXP_ALT_SO_PORT].func == `GXP_FUNC_ALT &&
		portCfg_r[`GXP_ALT_CS_PORT].func == `GXP_FUNC_ALT);

	// One pulse per debounce unit; the debouncers count these, not clocks.
	always_ff @(posedge clk) begin
		if (sys_rst || unitTick) begin
			unitCnt_r <= '0;
		end else begin
			unitCnt_r <= unitCnt_r + 1'b1;
		end
	end
	assign unitTick = unitCnt_r == CW'(UNIT_CYCLES - 1);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			syncA_r <= '0;
			syncB_r <= '0;
		end else begin
			syncA_r <= portIn;
			syncB_r <= syncA_r;
		end
	end

	for (genvar g = 0; g < NUM_PORTS; g++) begin : gPort
		localparam logic [7:0] OFS = `GXP_OFS_PORT0 + 8'(4 * g);
		localparam logic [2:0] SELCODE = 3'(g + 1);
		localparam bit ALT_PIN = (g == `GXP_ALT_SO_PORT) || (g == `GXP_ALT_CS_PORT);
		logic [1:0] funcPrev_r;
		logic [7:0] dbCnt_r;
		logic st_r;
		logic act;
		logic ignored;
		logic selA;
		logic selB;
		logic level;
		logic out_r;
		logic oe_r;
		logic pu_r;
		logic pd_r;

		always_ff @(posedge clk) begin
			if (sys_rst) begin
				portCfg_r[g] <= `GXP_PORT_RST;
			end else if (wrEn && avs_address == OFS) begin
				portCfg_r[g] <= (portCfg_r[g] & ~wmask[5:0]) | (avs_writedata[5:0] & wmask[5:0]);
			end
		end

		assign ignored = ALT_PIN && altMode;
		assign isInput[g] = portCfg_r[g].func == `GXP_FUNC_INPUT && !ignored;
		assign act = portCfg_r[g].polarity ? syncB_r[g] : ~syncB_r[g];
		assign preset[g] = !onMode_r || (onMode_r && !onPrev_r) ||
			(portCfg_r[g].func != funcPrev_r);

		always_ff @(posedge clk) begin
			if (sys_rst) begin
				funcPrev_r <= `GXP_FUNC_INPUT;
			end else begin
				funcPrev_r <= portCfg_r[g].func;
			end
		end

		// Status holds the active state; passive is zero, so a preset re-arms the edge.
		always_ff @(posedge clk) begin
			if (sys_rst || preset[g] || !isInput[g]) begin
				st_r <= 1'b0;
				dbCnt_r <= 8'h0;
			end else if (act == st_r) begin
				dbCnt_r <= 8'h0;
			end else if (!portCfg_r[g].behaviour) begin
				st_r <= act;
			end else if (unitTick) begin
				if (dbCnt_r + 8'h1 >= debounce_r) begin
					st_r <= act;
					dbCnt_r <= 8'h0;
				end else begin
					dbCnt_r <= dbCnt_r + 8'h1;
				end
			end
		end
		assign status[g] = st_r;

		assign selA = buck_r.pgPortA == SELCODE;
		assign selB = buck_r.pgPortB == SELCODE;
		// Shared port: both must be good; either failing drives it low at once.
		assign level = (selA || selB) ? ((!selA || powerGoodA) && (!selB || powerGoodB))
			: portCfg_r[g].behaviour;

		always_ff @(posedge clk) begin
			if (sys_rst || !onMode_r) begin
				out_r <= 1'b0;
				oe_r <= 1'b0;
				pu_r <= 1'b0;
				pd_r <= 1'b0;
			end else if (ignored) begin
				out_r <= (g == `GXP_ALT_SO_PORT) && ifSoData;
				oe_r <= (g == `GXP_ALT_SO_PORT) && ifSoOe;
				pu_r <= 1'b0;
				pd_r <= 1'b0;
			end else if (portCfg_r[g].func == `GXP_FUNC_OUTPUT) begin
				pd_r <= 1'b0;
				if (portCfg_r[g].openDrain) begin
					out_r <= 1'b0;
					oe_r <= !level;
					pu_r <= portCfg_r[g].pullEn;
				end else begin
					out_r <= level;
					oe_r <= 1'b1;
					pu_r <= 1'b0;
				end
			end else begin
				out_r <= 1'b0;
				oe_r <= 1'b0;
				pu_r <= 1'b0;
				pd_r <= portCfg_r[g].pullEn;
			end
		end
		assign portOut[g] = out_r;
		assign portOe[g] = oe_r;
		assign portPullUpEn[g] = pu_r;
		assign portPullDownEn[g] = pd_r;
	end

	// Events: a new edge in the clearing cycle wins, so nothing is lost.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prevStatus_r <= '0;
			event_r <= '0;
			irqN_r <= 1'b1;
		end else begin
			prevStatus_r <= status;
			event_r <= (event_r & ~((wrEn && avs_address == `GXP_OFS_EVENT && avs_byteenable[0])
				? avs_writedata[NUM_PORTS-1:0] : NUM_PORTS'(0)))
				| (status & ~prevStatus_r);
			irqN_r <= !(|(event_r & ~mask_r));
		end
	end
	assign interruptOut_n = irqN_r;

	// Any status change toggles, including the forced drop in OFF mode.
	// Software that cares should rewrite the select bits after returning to ON mode.
	always_comb begin
		vsel_nxt = vsel_r;
		if (wrEn && avs_address == `GXP_OFS_VSEL && avs_byteenable[0]) begin
			vsel_nxt = avs_writedata[2:0];
		end
		vsel_nxt[0] = vsel_nxt[0] ^ selBit(buck_r.vselInA, status ^ prevStatus_r);
		vsel_nxt[1] = vsel_nxt[1] ^ selBit(buck_r.vselInB, status ^ prevStatus_r);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			vsel_r <= `GXP_VSEL_RST;
		end else begin
			vsel_r <= vsel_nxt;
		end
	end
	assign buckAVoltageSel = vsel_r[0];
	assign buckBVoltageSel = vsel_r[1];
	assign inputSupplySel = vsel_r[2];

	// Bucks are registered from the selected status bit, so an edge on that input reconfigures them one cycle later.
	always_ff @(posedge clk) begin
		if (sys_rst || !onMode_r) begin
			buckAEn_r <= 1'b0;
			buckBEn_r <= 1'b0;
			buckAPd_r <= 1'b0;
			buckBPd_r <= 1'b0;
		end else begin
			buckAEn_r <= buck_r.enA || selBit(buck_r.enInA, status);
			buckBEn_r <= buck_r.enB || selBit(buck_r.enInB, status);
			buckAPd_r <= !(buck_r.enA || selBit(buck_r.enInA, status)) && !buck_r.pdDisA;
			buckBPd_r <= !(buck_r.enB || selBit(buck_r.enInB, status)) && !buck_r.pdDisB;
		end
	end
	assign buckAEn = buckAEn_r;
	assign buckBEn = buckBEn_r;
	assign buckAPulldownEn = buckAPd_r;
	assign buckBPulldownEn = buckBPd_r;

	// A cleared selector keeps the first address, so disabling selection is always safe.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr2_r <= 1'b0;
			ifCs_r <= 1'b0;
		end else begin
			addr2_r <= buck_r.addrSelEn && buck_r.addrInSel != 3'h0 &&
				!selBit(buck_r.addrInSel, status);
			ifCs_r <= altMode && syncB_r[`GXP_ALT_CS_PORT];
		end
	end
	assign useSecondAddr = addr2_r;
	assign ifChipSelect = ifCs_r;
endmodule : gxp_extender
`default_nettype wire

/* gxp_checker.sv */
// Purpose: Port-level assertions for the port extender.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Bound to every gxp_extender instance at the foot of this file.
`default_nettype none
module gxp_checker #(
	parameter int NUM_PORTS = 5
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic chipEnable,
	input wire logic [NUM_PORTS-1:0] portIn,
	input wire logic [NUM_PORTS-1:0] portOe,
	input wire logic [NUM_PORTS-1:0] portPullUpEn,
	input wire logic [NUM_PORTS-1:0] portPullDownEn,
	input wire logic ifChipSelect,
	input wire logic buckAEn,
	input wire logic buckBEn,
	input wire logic buckAPulldownEn,
	input wire logic buckBPulldownEn,
	input wire logic interruptOut_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	// Three low samples cover the mode flop plus the registered pin and buck outputs.
	sequence s_off;
		!chipEnable [*3];
	endsequence
	property p_bus; $rose(avs_read || avs_write) |-> s_one_wait; endproperty
	property p_unmapped;
		avs_read && !avs_waitrequest && avs_address > 8'h28 |-> avs_readdata == 32'h0;
	endproperty
	property p_off_ports;
		s_off |-> portOe == '0 && portPullUpEn == '0 && portPullDownEn == '0;
	endproperty
	property p_off_bucks;
		s_off |-> !buckAEn && !buckBEn && !buckAPulldownEn && !buckBPulldownEn;
	endproperty
	property p_pd_excl; !(buckAEn && buckAPulldownEn) && !(buckBEn && buckBPulldownEn); endproperty
	property p_cs_sync; ifChipSelect |-> $past(portIn[4], 2) || $past(portIn[4], 3); endproperty
	property p_rst_exit;
		$fell(sys_rst) |-> interruptOut_n && portOe == '0 && !buckAEn && !buckBEn;
	endproperty
	property p_irq_release;
		$rose(interruptOut_n) |-> $past(avs_write && !avs_waitrequest)
			|| $past(avs_write && !avs_waitrequest, 2);
	endproperty
	a_bus: assert property (p_bus) else $error("wait state not exactly one cycle");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_off_ports: assert property (p_off_ports) else $error("port active while off");
	a_off_bucks: assert property (p_off_bucks) else $error("buck active while off");
	a_pd_excl: assert property (p_pd_excl) else $error("pulldown with buck on");
	a_cs_sync: assert property (p_cs_sync) else $error("select not from synced pin");
	a_rst_exit: assert property (p_rst_exit) else $error("outputs not idle at reset exit");
	a_irq_release: assert property (p_irq_release) else $error("interrupt released alone");
endmodule : gxp_checker
bind gxp_extender gxp_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (.clk(clk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chipEnable(chipEnable),
	.portIn(portIn), .portOe(portOe), .portPullUpEn(portPullUpEn),
	.portPullDownEn(portPullDownEn), .ifChipSelect(ifChipSelect), .buckAEn(buckAEn),
	.buckBEn(buckBEn), .buckAPulldownEn(buckAPulldownEn), .buckBPulldownEn(buckBPulldownEn),
	.interruptOut_n(interruptOut_n));
`default_nettype wire

/* gxp_pad_model.sv */
// Purpose: Board side of the five port pins.
// Assumes: The bench never drives a pin that the extender drives.
// Notes: A floating pin toggles each cycle so no stale level hides a fault.
`default_nettype none
module gxp_pad_model (
	input wire logic clk,
	input wire logic [4:0] portOut,
	input wire logic [4:0] portOe,
	input wire logic [4:0] portPullUpEn,
	input wire logic [4:0] portPullDownEn,
	input wire logic [4:0] extLevel,
	input wire logic [4:0] extEn,
	output logic [4:0] pinLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flip = 1'b0;
	always @(posedge clk) flip <= ~flip;
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (portOe[i]) pinLevel[i] = portOut[i];
			else if (extEn[i]) pinLevel[i] = extLevel[i];
			else if (portPullUpEn[i]) pinLevel[i] = 1'b1;
			else if (portPullDownEn[i]) pinLevel[i] = 1'b0;
			else pinLevel[i] = flip;
		end
	end
endmodule : gxp_pad_model
`default_nettype wire

/* testbench.sv */
// Purpose: Directed scenarios for the port extender.
// Assumes: Debounce unit shortened to 10 cycles.
// Notes: Pins idle high; reset polarity makes that the passive level.
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic chipEn = 1'b1;
	logic pgA = 1'b0;
	logic pgB = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, got;
	logic [4:0] extLevel = 5'h1f;
	logic [4:0] extEn = 5'h1f;
	logic [4:0] pins, pOut, pOe, pUp, pDown;
	logic waitReq, aEn, bEn, aPd, bPd, aVsel, bVsel, supSel, secondAddr, irqN, ifCs;
	logic strap = 1'b0;
	logic soData = 1'b0;
	logic soOe = 1'b0;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	gxp_extender #(.UNIT_CYCLES(10)) dut (.clk(clk), .sys_rst(rst), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hf),
		.avs_readdata(rdat), .avs_waitrequest(waitReq), .chipEnable(chipEn),
		.fourWireStrap(strap), .portIn(pins), .portOut(pOut), .portOe(pOe),
		.portPullUpEn(pUp), .portPullDownEn(pDown), .ifSoData(soData), .ifSoOe(soOe),
		.ifChipSelect(ifCs), .powerGoodA(pgA), .powerGoodB(pgB), .buckAEn(aEn), .buckBEn(bEn),
		.buckAPulldownEn(aPd), .buckBPulldownEn(bPd), .buckAVoltageSel(aVsel),
		.buckBVoltageSel(bVsel), .inputSupplySel(supSel), .useSecondAddr(secondAddr),
		.interruptOut_n(irqN));
	gxp_pad_model u_pads (.clk(clk), .portOut(pOut), .portOe(pOe), .portPullUpEn(pUp),
		.portPullDownEn(pDown), .extLevel(extLevel), .extEn(extEn), .pinLevel(pins));
	initial forever #5 clk = ~clk;
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] act);
		n_compared++;
		if (act !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, act);
		end
	endtask : chk
	// Waitrequest is read right after each rising edge, before that edge's updates land.
	// The edge at which it reads low is the one that takes the access and the read data.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (waitReq !== 1'b0);
		got = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, exp, got);
	endtask : rdchk
	task automatic pause(input int n);
		repeat (n) @(posedge clk);
	endtask : pause
	task automatic t_regs;
		rdchk("debounce", 8'h14, 32'h0a);
		rdchk("port0", 8'h00, 32'h0);
		rdchk("buck", 8'h18, 32'h0);
		bus(1'b1, 8'h40, 32'hffffffff);
		rdchk("unmapped", 8'h40, 32'h0);
		rdchk("status idle", 8'h24, 32'h800);
		$display("test regs done");
	endtask : t_regs
	task automatic t_event;
		bus(1'b1, 8'h00, 32'h04);
		pause(12);
		rdchk("status0", 8'h24, 32'h801);
		rdchk("event0", 8'h1c, 32'h1);
		chk("irq set", 0, irqN);
		bus(1'b1, 8'h1c, 32'h1);
		pause(4);
		chk("irq released", 1, irqN);
		rdchk("event cleared", 8'h1c, 32'h0);
		bus(1'b1, 8'h20, 32'h1);
		extLevel[0] <= 1'b0;
		pause(12);
		extLevel[0] <= 1'b1;
		pause(12);
		rdchk("masked event", 8'h1c, 32'h1);
		chk("irq masked", 1, irqN);
		bus(1'b1, 8'h20, 32'h0);
		pause(4);
		chk("irq unmasked", 0, irqN);
		bus(1'b1, 8'h1c, 32'h1f);
		$display("test event done");
	endtask : t_event
	task automatic t_buck;
		bus(1'b1, 8'h18, 32'h4);
		pause(6);
		chk("buckA by input", 1, aEn);
		chk("buckB pulldown", 1, bPd);
		extLevel[0] <= 1'b0;
		pause(12);
		chk("buckA input off", 2'b01, {aEn, aPd});
		bus(1'b1, 8'h18, 32'hc006);
		pause(4);
		chk("buckB by bit", 2'b10, {bEn, bPd});
		chk("buckA pd disabled", 0, aPd);
		chipEn <= 1'b0;
		pause(6);
		chk("bucks off", 4'h0, {aEn, bEn, aPd, bPd});
		chk("ports off", 5'h0, pOe);
		extLevel[0] <= 1'b1;
		pause(2);
		chipEn <= 1'b1;
		pause(12);
		chk("buckA at on entry", 1, aEn);
		rdchk("event at on entry", 8'h1c, 32'h1);
		bus(1'b1, 8'h1c, 32'h1f);
		bus(1'b1, 8'h18, 32'h0);
		$display("test buck done");
	endtask : t_buck
	task automatic t_out;
		bus(1'b1, 8'h08, 32'h0a);
		extEn[2] <= 1'b0;
		pause(4);
		chk("out high", 2'b11, {pOe[2], pOut[2]});
		bus(1'b1, 8'h08, 32'h02);
		pause(4);
		chk("out low", 2'b10, {pOe[2], pOut[2]});
		bus(1'b1, 8'h18, 32'h1b0000);
		pgA <= 1'b1;
		pause(4);
		chk("pg one good", 0, pOut[2]);
		pgB <= 1'b1;
		pause(4);
		chk("pg both good", 1, pOut[2]);
		pgA <= 1'b0;
		pause(4);
		chk("pg dropped", 0, pOut[2]);
		bus(1'b1, 8'h18, 32'h0);
		bus(1'b1, 8'h08, 32'h3a);
		pause(4);
		chk("od released", 2'b01, {pOe[2], pUp[2]});
		bus(1'b1, 8'h08, 32'h32);
		pause(4);
		chk("od pulled low", 2'b10, {pOe[2], pOut[2]});
		bus(1'b1, 8'h08, 32'h0);
		extEn[2] <= 1'b1;
		$display("test out done");
	endtask : t_out
	task automatic t_addr_vsel;
		bus(1'b1, 8'h18, 32'hc00000);
		pause(4);
		chk("addr active", 0, secondAddr);
		extLevel[0] <= 1'b0;
		pause(12);
		chk("addr passive", 1, secondAddr);
		bus(1'b1, 8'h18, 32'h400000);
		pause(4);
		chk("addr none", 0, secondAddr);
		bus(1'b1, 8'h18, 32'h200);
		extLevel[1] <= 1'b0;
		pause(12);
		chk("vsel first edge", 1, aVsel);
		extLevel[1] <= 1'b1;
		pause(12);
		chk("vsel second edge", 0, aVsel);
		bus(1'b1, 8'h28, 32'h6);
		pause(2);
		chk("vsel reg", 3'h6, {supSel, bVsel, aVsel});
		bus(1'b1, 8'h28, 32'h0);
		$display("test addr vsel done");
	endtask : t_addr_vsel
	// Ten units of ten cycles: the status must still be passive at 60 and active by 120.
	task automatic t_debounce;
		bus(1'b1, 8'h0c, 32'h08);
		extLevel[3] <= 1'b0;
		pause(60);
		rdchk("debounce early", 8'h24, 32'h800);
		pause(60);
		rdchk("debounce late", 8'h24, 32'h808);
		extLevel[3] <= 1'b1;
		bus(1'b1, 8'h14, 32'h01);
		pause(30);
		rdchk("short debounce", 8'h24, 32'h800);
		bus(1'b1, 8'h0c, 32'h0);
		bus(1'b1, 8'h14, 32'h0a);
		$display("test debounce done");
	endtask : t_debounce
	task automatic t_iface;
		bus(1'b1, 8'h10, 32'h14);
		extEn[4] <= 1'b0;
		pause(6);
		chk("pulldown", 1, pDown[4]);
		chk("pulled input", 0, pins[4]);
		extEn[4] <= 1'b1;
		bus(1'b1, 8'h0c, 32'h01);
		extEn[3] <= 1'b0;
		soOe <= 1'b1;
		soData <= 1'b1;
		bus(1'b1, 8'h10, 32'h11);
		pause(4);
		rdchk("alt status", 8'h24, 32'hc00);
		chk("so driven", 2'b11, {pOe[3], pOut[3]});
		chk("pull ignored", 0, pDown[4]);
		chk("cs follows pin", 1, ifCs);
		extLevel[4] <= 1'b0;
		pause(6);
		chk("cs low", 0, ifCs);
		extLevel[4] <= 1'b1;
		soOe <= 1'b0;
		pause(2);
		extEn[3] <= 1'b1;
		bus(1'b1, 8'h0c, 32'h0);
		bus(1'b1, 8'h10, 32'h0);
		bus(1'b1, 8'h1c, 32'h1f);
		$display("test iface done");
	endtask : t_iface
	// Second reset with the strap high: port 0 pin is low, so its reset polarity makes it active.
	task automatic t_strap;
		rst <= 1'b1;
		strap <= 1'b1;
		pause(4);
		rst <= 1'b0;
		pause(6);
		rdchk("strap status", 8'h24, 32'hc01);
		chk("strap cs", 1, ifCs);
		$display("test strap done");
	endtask : t_strap
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_event();
		t_buck();
		t_out();
		t_addr_vsel();
		t_debounce();
		t_iface();
		t_strap();
		final_report();
	end
endmodule : testbench
`default_nettype wire
